// file: pbsi_core.sv
// synchronous control decode, byte writes and output drive of the sram
// Notes on behaviour
// - processor strobe start while selected begins a read, writes ignored
// - controller strobe start begins write if write term low, else read
// - never write on processor strobe start cycle itself
// - both strobes inactive with advance low steps burst address
// - advance high repeats access at current burst address
// - write term low on global write or lane enable with a lane
// - lane writes touch only selected lanes, parity included
// - global write writes all lanes regardless of lane selects
// - output enable asynchronous and masked during writes
// - read cycles drive data when output enable low
// - deselect cases float data pins
// - variant without third select treats it as active
// - sleep floats data and ignores synchronous inputs
// - after deselect outputs float one edge later
// - two-bit wrapping counter, interleaved or linear order
`timescale 1ns/1ps
module pbsi_core
  import pbsi_pkg::*;
#(
  parameter int ADDR_BITS   = 20,
  parameter int LANES       = PBSI_LANES_WIDE,
  parameter bit HAS_THIRD   = 1'b1,
  parameter int DEPTH_WORDS = 1024
)
(
  input  wire logic                          sys_clk,
  input  wire logic                          resetn,
  input  wire pbsi_ctrl_type                 ctrl,
  input  wire logic [LANES-1:0]              lane_write_select_n,
  input  wire logic [ADDR_BITS-1:0]          address,
  input  wire logic                          order_select,
  input  wire logic                          sleep_request,
  input  wire logic                          output_enable_n,
  input  wire logic [LANES*PBSI_LANE_BITS-1:0] data_in,
  output logic      [LANES*PBSI_LANE_BITS-1:0] data_out,
  output logic      [LANES*PBSI_LANE_BITS-1:0] data_oe_n
);

  localparam int WIDTH = LANES * PBSI_LANE_BITS;
  localparam int IDX_BITS = $clog2(DEPTH_WORDS);

  logic [WIDTH-1:0] mem [DEPTH_WORDS];

  pbsi_op_type            op;
  logic                   chip_selected;
  logic                   third_active;
  logic                   write_term;
  logic                   is_write;
  logic [LANES-1:0]       lane_mask;
  logic                   load;
  logic                   advance;
  logic [ADDR_BITS-1:0]   base_addr;
  logic [ADDR_BITS-1:0]   next_base_addr;
  logic [PBSI_BURST_BITS-1:0] burst_bits;
  logic [ADDR_BITS-1:0]   access_addr;
  logic                   active;
  logic                   next_active;
  logic                   drive_stage;
  logic                   next_drive_stage;
  logic                   read_stage;
  logic                   next_read_stage;
  logic                   write_now;
  logic [WIDTH-1:0]       next_data_out;
  logic [WIDTH-1:0]       write_word;
  logic [IDX_BITS-1:0]    wr_idx;
  logic [IDX_BITS-1:0]    rd_idx;

  ////////////////////////////////////////////////////////////////////////
  // cycle decode

  assign third_active  = HAS_THIRD ? !ctrl.chip_select_third_n : 1'b1;
  assign chip_selected = !ctrl.chip_select_first_n && ctrl.chip_select_second
                         && third_active;

  assign write_term = !ctrl.global_write_n
                      || (!ctrl.lane_write_enable_n && !(&lane_write_select_n));

  always_comb begin
    op = PBSI_OP_SUSPEND;
    if (sleep_request) begin
      op = PBSI_OP_SLEEP;
    end else if ((ctrl.chip_select_first_n
                  && !ctrl.controller_address_strobe_n)
                 || (!ctrl.chip_select_first_n && !chip_selected
                     && (!ctrl.processor_address_strobe_n
                         || !ctrl.controller_address_strobe_n))) begin
      op = PBSI_OP_DESELECT;
    end else if (chip_selected && (!ctrl.processor_address_strobe_n
                 || !ctrl.controller_address_strobe_n)) begin
      op = PBSI_OP_BEGIN;
    end else if (!ctrl.burst_advance_n) begin
      op = PBSI_OP_CONTINUE;
    end else begin
      op = PBSI_OP_SUSPEND;
    end
  end

  always_comb begin
    is_write = 1'b0;
    case (op)
      PBSI_OP_BEGIN:
        is_write = ctrl.processor_address_strobe_n && write_term;
      PBSI_OP_CONTINUE,
      PBSI_OP_SUSPEND:
        is_write = active && write_term;
      default:
        is_write = 1'b0;
    endcase
  end

  // per lane write mask and merged word
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign lane_mask[g] = !ctrl.global_write_n
                            || (!ctrl.lane_write_enable_n
                                && !lane_write_select_n[g]);
      // unselected lanes keep their stored bits, parity included
      assign write_word[g*PBSI_LANE_BITS +: PBSI_LANE_BITS] =
        lane_mask[g] ? data_in[g*PBSI_LANE_BITS +: PBSI_LANE_BITS]
                     : mem[wr_idx][g*PBSI_LANE_BITS +: PBSI_LANE_BITS];
    end
  endgenerate

  assign load    = (op == PBSI_OP_BEGIN);
  assign advance = (op == PBSI_OP_CONTINUE) && active;

  pbsi_burst_counter u_counter (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .load        (load),
    .advance     (advance),
    .start_bits  (address[PBSI_BURST_BITS-1:0]),
    .interleaved (order_select),
    .burst_bits  (burst_bits)
  );

  ////////////////////////////////////////////////////////////////////////
  // address and state registers

  always_comb begin
    next_base_addr = load ? address : base_addr;
    next_active    = active;
    case (op)
      PBSI_OP_BEGIN:    next_active = 1'b1;
      PBSI_OP_DESELECT: next_active = 1'b0;
      PBSI_OP_SLEEP:    next_active = 1'b0;
      default:          next_active = active;
    endcase
  end

  // current access uses the fresh address on a begin cycle
  assign access_addr = load ? address
                     : {base_addr[ADDR_BITS-1:PBSI_BURST_BITS], burst_bits};
  assign write_now = is_write && (load || active);
  assign wr_idx = access_addr[IDX_BITS-1:0];
  assign rd_idx = access_addr[IDX_BITS-1:0];

  // output stage: floats one edge after deselect
  always_comb begin
    next_drive_stage = drive_stage;
    next_read_stage  = 1'b0;
    case (op)
      PBSI_OP_BEGIN,
      PBSI_OP_CONTINUE,
      PBSI_OP_SUSPEND: begin
        next_drive_stage = (load || active);
        next_read_stage  = (load || active) && !is_write;
      end
      // deselect keeps a pending read driven for one more cycle
      PBSI_OP_DESELECT: begin
        next_drive_stage = 1'b0;
        next_read_stage  = drive_stage && read_stage;
      end
      PBSI_OP_SLEEP:    next_drive_stage = 1'b0;
      default:          next_drive_stage = 1'b0;
    endcase
  end

  always_comb begin
    next_data_out = data_out;
    if (next_read_stage && next_drive_stage) begin
      next_data_out = mem[rd_idx];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      base_addr   <= '0;
      active      <= PBSI_RESET_LOW;
      drive_stage <= PBSI_RESET_LOW;
      read_stage  <= PBSI_RESET_LOW;
      data_out    <= '0;
    end else begin
      base_addr   <= next_base_addr;
      active      <= next_active;
      drive_stage <= next_drive_stage;
      read_stage  <= next_read_stage;
      data_out    <= next_data_out;
    end
  end

  // lane write into array
  // one process writes whole merged words, so the array has one driver
  always_ff @(posedge sys_clk) begin
    if (write_now) begin
      mem[wr_idx] <= write_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // asynchronous output enable; low enable means drive

  assign data_oe_n = {WIDTH{!(read_stage && !is_write
                              && !output_enable_n && !sleep_request)}};

endmodule

// file: pbsi_pkg.sv
// shared constants and types for the pipelined burst sram interface
package pbsi_pkg;

  localparam int PBSI_LANES_WIDE   = 4;
  localparam int PBSI_LANES_NARROW = 2;
  localparam int PBSI_LANE_BITS    = 9;
  localparam int PBSI_BURST_BITS   = 2;
  localparam logic [1:0] PBSI_BURST_ONE = 2'h1;
  localparam logic PBSI_RESET_LOW = 1'b0;
  // sleep exit recovery, in clock periods
  localparam int PBSI_SLEEP_RECOVERY_CYCLES = 2;

  // operation decoded at a rising clock
  typedef enum logic [2:0] {
    PBSI_OP_DESELECT,
    PBSI_OP_BEGIN,
    PBSI_OP_CONTINUE,
    PBSI_OP_SUSPEND,
    PBSI_OP_SLEEP
  } pbsi_op_type;

  // sampled synchronous control pins
  typedef struct packed {
    logic chip_select_first_n;
    logic chip_select_second;
    logic chip_select_third_n;
    logic processor_address_strobe_n;
    logic controller_address_strobe_n;
    logic burst_advance_n;
    logic global_write_n;
    logic lane_write_enable_n;
  } pbsi_ctrl_type;

endpackage

// file: pbsi_burst_counter.sv
// two-bit wrapping burst counter, interleaved or linear order
`timescale 1ns/1ps
module pbsi_burst_counter
  import pbsi_pkg::*;
(
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  input  wire logic                       load,
  input  wire logic                       advance,
  input  wire logic [PBSI_BURST_BITS-1:0] start_bits,
  input  wire logic                       interleaved,
  output logic      [PBSI_BURST_BITS-1:0] burst_bits
);

  logic [PBSI_BURST_BITS-1:0] first_bits;
  logic [PBSI_BURST_BITS-1:0] step;
  logic [PBSI_BURST_BITS-1:0] next_first_bits;
  logic [PBSI_BURST_BITS-1:0] next_step;

  always_comb begin
    next_first_bits = first_bits;
    next_step       = step;
    if (load) begin
      next_first_bits = start_bits;
      next_step       = '0;
    end else if (advance) begin
      next_step = step + PBSI_BURST_ONE;
    end
  end

  // address of this cycle: an advance already shows the stepped value,
  // so a continue touches the next word, not the one it stepped from;
  // interleaved xors step into start, linear adds it
  always_comb begin
    if (interleaved) begin
      burst_bits = next_first_bits ^ next_step;
    end else begin
      burst_bits = next_first_bits + next_step;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      first_bits <= '0;
      step       <= '0;
    end else begin
      first_bits <= next_first_bits;
      step       <= next_step;
    end
  end

endmodule

// file: pbsi_core_checker.sv
// assertions on the pins of the sram interface core
`timescale 1ns/1ps
module pbsi_core_checker
  import pbsi_pkg::*;
#(
  parameter int LANES = PBSI_LANES_WIDE,
  parameter int W     = LANES*PBSI_LANE_BITS
)
(
  input wire logic             sys_clk,
  input wire logic             resetn,
  input wire pbsi_ctrl_type    ctrl,
  input wire logic [LANES-1:0] lane_write_select_n,
  input wire logic             sleep_request,
  input wire logic             output_enable_n,
  input wire logic [W-1:0]     data_out,
  input wire logic [W-1:0]     data_oe_n
);
  logic c1n, c2, c3n, psn, csn, gwn, lwn, wtn, sel, ds, pb, wb, cw, rdy;
  // pin decode; a low write term marks a write
  assign {c1n, c2, c3n, psn, csn} = ctrl[7:3];
  assign {gwn, lwn} = ctrl[1:0];
  assign wtn = gwn && (lwn || &lane_write_select_n);
  assign sel = !c1n && c2 && !c3n && !sleep_request;
  assign pb = sel && !psn;
  assign wb = sel && psn && !csn && !wtn;
  assign cw = psn && csn && !wtn && !sleep_request;
  assign rdy = !output_enable_n && wtn && !sleep_request;
  assign ds = !sleep_request &&
              (c1n ? !csn : (!psn || !csn) && (!c2 || c3n));
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  sequence rd_s;
    pb ##1 (wtn && !sleep_request);
  endsequence
  sequence hold_s;
    !ds ##1 (ds && ~|data_oe_n);
  endsequence
  oe_float_a: assert property (output_enable_n |-> &data_oe_n)
    else $error("driven with oe high");
  sleep_float_a: assert property (sleep_request |-> &data_oe_n)
    else $error("driven in sleep");
  wr_mask_a: assert property (wb |-> &data_oe_n)
    else $error("driven on write");
  burst_mask_a: assert property (wb ##1 cw |-> &data_oe_n)
    else $error("driven on burst write");
  read_drive_a: assert property (rd_s ##1 rdy |-> ~|data_oe_n)
    else $error("read not driven");
  desel_hold_a: assert property (hold_s ##1 rdy |-> ~|data_oe_n)
    else $error("drive dropped early");
  desel_float_a: assert property (ds [*2] |=> &data_oe_n)
    else $error("driven after deselect");
  write_keep_a: assert property (wb |=> $stable(data_out))
    else $error("read data moved on write");
endmodule
bind pbsi_core pbsi_core_checker #(.LANES(LANES)) chk_u (
  .sys_clk(sys_clk), .resetn(resetn), .ctrl(ctrl),
  .lane_write_select_n(lane_write_select_n), .sleep_request(sleep_request),
  .output_enable_n(output_enable_n), .data_out(data_out),
  .data_oe_n(data_oe_n));

// file: pbsi_host_model.sv
// host model driving the sram control, address and data pins
`timescale 1ns/1ps
module pbsi_host_model
  import pbsi_pkg::*;
(
  input  wire logic    sys_clk,
  output pbsi_ctrl_type ctrl,
  output logic [3:0]   lane_write_select_n,
  output logic [19:0]  address,
  output logic         sleep_request,
  output logic         output_enable_n,
  output logic [35:0]  data_in
);
  // pins start idle: deselected, oe high
  initial begin
    ctrl = pbsi_ctrl_type'(8'hd7);
    lane_write_select_n = 4'hf;
    address = 20'h0;
    sleep_request = 1'b0;
    output_enable_n = 1'b1;
    data_in = 36'h0;
  end
  // one bus cycle, driven after an edge and held to the next
  task automatic cyc(input logic [7:0] c, input logic [3:0] ln,
                     input logic [19:0] a, input logic [35:0] d,
                     input logic oe);
    logic wr;
    wr = !c[1] || (!c[0] && !(&ln));
    @(posedge sys_clk);
    ctrl <= pbsi_ctrl_type'(c);
    lane_write_select_n <= ln;
    address <= a;
    output_enable_n <= (wr && !c[3]) ? 1'b1 : oe;
    // released bus shows its last value inverted
    data_in <= wr ? d : ~data_in;
  endtask
  // deselect, then sleep with first select and strobes inactive
  task automatic nap(input int n);
    cyc(8'hd7, 4'hf, 20'h0, 36'h0, 1'b1);
    cyc(8'hdf, 4'hf, 20'h0, 36'h0, 1'b1);
    sleep_request <= 1'b1;
    repeat (n) @(posedge sys_clk);
    sleep_request <= 1'b0;
    // recovery: strobes stay high, a deselect would pull one low
    repeat (PBSI_SLEEP_RECOVERY_CYCLES) cyc(8'hdf, 4'hf, 20'h0, 36'h0, 1'b1);
  endtask
endmodule

// file: tb.sv
// self-checking bench for the sram interface core
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  err_count++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
  import pbsi_pkg::*;
  localparam logic [7:0] IDLE = 8'hd7, PBR = 8'h4f, CONT = 8'hdb;
  logic          sys_clk = 1'b0;
  logic          resetn = 1'b0;
  logic          order_select = 1'b0;
  pbsi_ctrl_type ctrl;
  logic [3:0]    lane_write_select_n;
  logic [19:0]   address;
  logic          sleep_request, output_enable_n;
  logic [35:0]   data_in, data_out, data_oe_n;
  int            err_count = 0;
  int            total_checks = 0;
  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;
  pbsi_host_model h_u (.sys_clk(sys_clk), .ctrl(ctrl),
    .lane_write_select_n(lane_write_select_n), .address(address),
    .sleep_request(sleep_request), .output_enable_n(output_enable_n),
    .data_in(data_in));
  pbsi_core dut_u (.sys_clk(sys_clk), .resetn(resetn), .ctrl(ctrl),
    .lane_write_select_n(lane_write_select_n), .address(address),
    .order_select(order_select), .sleep_request(sleep_request),
    .output_enable_n(output_enable_n), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n));
  function automatic logic [35:0] pat(input logic [1:0] a);
    pat = {4{7'h5a, a}};
  endfunction
  // read one word, look at data and drive two edges on
  task automatic rd(input logic [7:0] c, input logic [1:0] a,
                    input logic oe, input logic [35:0] e);
    h_u.cyc(c, 4'hf, {18'h0, a}, '0, oe);
    h_u.cyc(IDLE, 4'hf, '0, '0, oe);
    @(posedge sys_clk);
    #1;
    `CHK("read data", e, data_out)
    `CHK("read drive", {36{oe}}, data_oe_n)
  endtask
  task automatic t_global();
    for (int a = 0; a < 4; a++)
      h_u.cyc(8'h54, 4'he, 20'(a), pat(2'(a)), 1'b0);
    for (int a = 0; a < 4; a++)
      rd(PBR, 2'(a), 1'b0, pat(2'(a)));
  endtask
  // processor start with write inputs low
  task automatic t_pstart();
    rd(8'h4c, 2'h1, 1'b0, pat(2'h1));
    rd(PBR, 2'h1, 1'b0, pat(2'h1));
  endtask
  task automatic t_lanes();
    h_u.cyc(8'h56, 4'ha, 20'h0, '0, 1'b0);
    h_u.cyc(8'h56, 4'hf, 20'h1, '0, 1'b0);
    rd(PBR, 2'h0, 1'b0, pat(2'h0) & {9'h1ff, 9'h0, 9'h1ff, 9'h0});
    rd(PBR, 2'h1, 1'b0, pat(2'h1));
  endtask
  // burst write, read bursts in both orders
  task automatic t_burst();
    logic [35:0] nx;
    h_u.cyc(8'h55, 4'hf, 20'h0, pat(2'h0), 1'b0);
    for (int a = 1; a < 4; a++)
      h_u.cyc(8'hd9, 4'hf, '0, pat(2'(a)), 1'b0);
    h_u.cyc(IDLE, 4'hf, '0, '0, 1'b0);
    for (int o = 0; o < 2; o++) begin
      @(posedge sys_clk);
      order_select <= o[0];
      nx = pat(o[0] ? 2'h0 : 2'h2);
      h_u.cyc(PBR, 4'hf, 20'h1, '0, 1'b0);
      h_u.cyc(CONT, 4'hf, '0, '0, 1'b0);
      #1;
      `CHK("burst first", pat(2'h1), data_out)
      h_u.cyc(8'hdf, 4'hf, '0, '0, 1'b0);
      #1;
      `CHK("burst second", nx, data_out)
      h_u.cyc(CONT, 4'hf, '0, '0, 1'b0);
      #1;
      `CHK("burst held", nx, data_out)
      h_u.cyc(IDLE, 4'hf, '0, '0, 1'b0);
      #1;
      `CHK("burst third", pat(2'h3), data_out)
    end
  endtask
  task automatic t_desel();
    logic [7:0] ds [3] = '{IDLE, 8'h0f, 8'h77};
    foreach (ds[i]) begin
      h_u.cyc(PBR, 4'hf, 20'h3, '0, 1'b0);
      h_u.cyc(ds[i], 4'hf, '0, '0, 1'b0);
      @(posedge sys_clk);
      #1;
      `CHK("deselect hold", '0, data_oe_n)
      @(posedge sys_clk);
      #1;
      `CHK("deselect float", '1, data_oe_n)
    end
  endtask
  // oe high read, then sleep keeps data
  task automatic t_sleep();
    rd(PBR, 2'h2, 1'b1, pat(2'h2));
    h_u.nap(3);
    rd(PBR, 2'h2, 1'b0, pat(2'h2));
  endtask
  task automatic close_out();
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // reset, scenarios, verdict
  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    `CHK("reset drive", '1, data_oe_n)
    `CHK("reset data", '0, data_out)
    @(posedge sys_clk);
    resetn <= 1'b1;
    t_global();
    t_pstart();
    t_lanes();
    t_burst();
    t_desel();
    t_sleep();
    close_out();
  end
  // hang guard, far past the 78 cycles needed
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_count++;
    close_out();
  end
endmodule
